// [include/dwps_defs.svh]
/*
 * Constants of the waveform playback sequencer: register offsets,
 * field positions, word layout, memory geometry and timing counts.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef DWPS_DEFS_SVH
`define DWPS_DEFS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define DWPS_CTRL_OFS 12'h000
`define DWPS_MANUAL_OFS 12'h004
`define DWPS_UPDATE_OFS 12'h008
`define DWPS_MEM_ADDR_OFS 12'h00c
`define DWPS_MEM_DATA_OFS 12'h010
`define DWPS_TIMER_OFS 12'h014
`define DWPS_STATUS_OFS 12'h018

// ****************************************
// Control fields
// ****************************************
`define DWPS_CTRL_PLAY 0
`define DWPS_CTRL_STOP 1
`define DWPS_CTRL_ILOCK_EN 2
`define DWPS_CTRL_SIMUL 3

// ****************************************
// Waveform word layout
// ****************************************
`define DWPS_WORD_W 16
`define DWPS_CODE_W 12
`define DWPS_HALT_BIT 15
`define DWPS_FRAME_BIT 14
`define DWPS_LAST_BIT 13
`define DWPS_LOOP_BIT 12
`define DWPS_NIB_BLANK_OFF 4'h9
`define DWPS_NIB_BLANK_ON 4'hb
`define DWPS_NIB_RSVD_A 4'hd
`define DWPS_NIB_RSVD_B 4'hf

// ****************************************
// Geometry and timing
// ****************************************
`define DWPS_NUM_CH 8
`define DWPS_CH_W 3
`define DWPS_MEM_AW 17
`define DWPS_BANK_AW 16
`define DWPS_BANK_WORDS 65536
`define DWPS_CLK_MHZ 200
`define DWPS_LEADIN_US 500
`define DWPS_LEADIN_CYCLES (`DWPS_LEADIN_US * `DWPS_CLK_MHZ)

`endif

// [include/dwps_pkg.sv]
/*
 * Types of the waveform playback sequencer: engine states, code
 * arrays and the packed state record of the top module.
 * Assumes dwps_defs.svh is on the include path.
 */
`include "dwps_defs.svh"

package dwps_pkg;

	// ****************************************
	// Engine states
	// ****************************************
	typedef enum logic [1:0] {
		DWPS_IDLE = 2'b00,
		DWPS_RUN = 2'b01,
		DWPS_LOAD = 2'b10
	} dwps_state_t;

	// ****************************************
	// Data types
	// ****************************************
	typedef logic [`DWPS_CODE_W-1:0] dwps_code_t;
	typedef logic [`DWPS_NUM_CH-1:0][`DWPS_CODE_W-1:0] dwps_codes_t;

	// All state of the top module
	typedef struct packed {
		logic [2:0] trig_sync;
		logic [1:0] pause_sync;
		logic [1:0] ilock_sync;
		logic [1:0] loop_sync;
		dwps_state_t state;
		logic [`DWPS_MEM_AW-1:0] rd_ptr;
		logic [`DWPS_CH_W-1:0] ch;
		dwps_codes_t dac;
		dwps_codes_t stage;
		dwps_codes_t out;
		logic frame;
		logic last;
		logic blank;
		logic ilock_en;
		logic simul;
		logic [`DWPS_MEM_AW-1:0] mem_addr;
		logic [15:0] timer_reload;
		logic [15:0] timer_cnt;
		logic [31:0] leadin_cnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dwps_state_rec_t;

endpackage

// [design/dwps_wave_mem.sv]
/*
 * Waveform storage: two banks of 64k 16-bit words, one write port
 * and one read port with registered read data.
 * Assumes a single clock; read data valid one cycle after rd_en.
 */
`include "dwps_defs.svh"

module dwps_wave_mem (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [`DWPS_MEM_AW-1:0] wr_addr,
	input wire logic [`DWPS_WORD_W-1:0] wr_data,
	// Read port
	input wire logic rd_en,
	input wire logic [`DWPS_MEM_AW-1:0] rd_addr,
	output logic [`DWPS_WORD_W-1:0] rd_data
);

	logic [`DWPS_WORD_W-1:0] bank_lo [0:`DWPS_BANK_WORDS-1];
	logic [`DWPS_WORD_W-1:0] bank_hi [0:`DWPS_BANK_WORDS-1];

	// Write into the bank chosen by the top address bit
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			if (wr_addr[`DWPS_BANK_AW]) begin
				bank_hi[wr_addr[`DWPS_BANK_AW-1:0]] <= wr_data; // [R2]
			end else begin
				bank_lo[wr_addr[`DWPS_BANK_AW-1:0]] <= wr_data; // [R2]
			end
		end
	end

	// Registered read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_data <= 16'h0000;
		end else if (rd_en) begin
			if (rd_addr[`DWPS_BANK_AW]) begin
				rd_data <= bank_hi[rd_addr[`DWPS_BANK_AW-1:0]];
			end else begin
				rd_data <= bank_lo[rd_addr[`DWPS_BANK_AW-1:0]];
			end
		end
	end

endmodule

// [design/dwps_top.sv]
/*
 * Eight channel DAC sequencer: APB register slave, manual updates,
 * paced playback from waveform memory, control pins and flag pins.
 * Assumes pins are asynchronous to clk_sys, a single 200 MHz clock
 * and a synchronous active-high reset.
 */
// Added by the designer: the register offsets and register access over APB.
`include "dwps_defs.svh"

// Overview of operation
// [R1] Word: four flags on top, 12-bit code
// [R2] Memory is two 64k banks, 128k total
// [R3] One word fetched per pacing strobe
// [R4] Play by command or trigger falling edge
// [R5] Pause low holds playback in place
// [R6] Channels count up; last flag returns to 0
// [R7] Last-channel flag drives its output pin
// [R8] Frame flag drives its output pin
// [R9] Flag pins hold until next channel 0
// [R10] Halt flag stops after word is output
// [R11] Without halt, memory repeats forever
// [R12] Loop flag returns to first word
// [R13] Loop works only with loop enable high
// [R14] Flag nibble decodes; blank and reserved codes
// [R15] Blank pin set by 1011, cleared 1001
// [R16] Enabled interlock high forces outputs zero
// [R17] Outputs held zero during power-up lead-in
// [R18] Manual individual or simultaneous updates
// [R19] Software preloads, plays, keeps streaming
// [R20] Software marks last word with loop
// [R21] Start and loop reset pointer, channel
module dwps_top #(
	parameter int unsigned LEADIN_CYCLES = `DWPS_LEADIN_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Control pins, pulled up
	input wire logic trig_n,
	input wire logic pause_n,
	input wire logic ilock,
	input wire logic loop_en,
	// Converter codes
	output dwps_pkg::dwps_codes_t dac_codes,
	// Status pins
	output logic frame_out,
	output logic last_channel_out,
	output logic blank_out
);

	// ****************************************
	// State and memory wiring
	// ****************************************
	dwps_pkg::dwps_state_rec_t s_reg;
	dwps_pkg::dwps_state_rec_t s_next;
	logic mem_we;
	logic mem_re;
	logic [`DWPS_WORD_W-1:0] mem_rdata;

	// Waveform store
	// Host writes and playback reads use separate ports and pointers
	dwps_wave_mem u_mem (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(mem_we),
		.wr_addr(s_reg.mem_addr),
		.wr_data(pwdata[`DWPS_WORD_W-1:0]),
		.rd_en(mem_re),
		.rd_addr(s_reg.rd_ptr),
		.rd_data(mem_rdata)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		// Scratch signals of this cycle
		logic strobe;
		logic play_cmd;
		logic stop_cmd;
		logic trig_fall;
		logic apb_wr;
		logic leadin;
		logic zero_out;
		logic [3:0] nib;
		logic is_cmd;
		logic f_halt;
		logic f_frame;
		logic f_last;
		logic f_loop;
		logic ch0;
		// Defaults: nothing happens unless a branch below asks for it
		strobe = 1'b0;
		play_cmd = 1'b0;
		stop_cmd = 1'b0;
		trig_fall = 1'b0;
		apb_wr = 1'b0;
		leadin = 1'b0;
		zero_out = 1'b0;
		nib = 4'h0;
		is_cmd = 1'b0;
		f_halt = 1'b0;
		f_frame = 1'b0;
		f_last = 1'b0;
		f_loop = 1'b0;
		ch0 = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		s_next = s_reg;

		// Two-flop synchronisers; the trigger has a third for edges
		// Reset fills them with zeros, so the trigger shows no false fall
		// while its pipe fills with the idle high level
		s_next.trig_sync = {s_reg.trig_sync[1:0], trig_n};
		s_next.pause_sync = {s_reg.pause_sync[0], pause_n};
		s_next.ilock_sync = {s_reg.ilock_sync[0], ilock};
		s_next.loop_sync = {s_reg.loop_sync[0], loop_en};
		trig_fall = s_reg.trig_sync[2] & ~s_reg.trig_sync[1]; // [R4]

		// Pacing timer: one strobe every reload+1 cycles
		// A strobe in the load cycle is dropped, so reload must be 1 or more
		if (s_reg.timer_cnt == 16'h0000) begin
			strobe = 1'b1; // [R3]
			s_next.timer_cnt = s_reg.timer_reload;
		end else begin
			s_next.timer_cnt = s_reg.timer_cnt - 16'h0001;
		end

		// Power-up lead-in counter
		// Counts once after reset and then rests at its ceiling
		leadin = (s_reg.leadin_cnt < LEADIN_CYCLES);
		if (leadin) begin
			s_next.leadin_cnt = s_reg.leadin_cnt + 32'h0000_0001;
		end

		// APB setup cycle: decode and register the answer
		// Zero wait states: pready is the registered setup decode
		// Read data is built here so it stands through the access cycle
		s_next.pready = 1'b0;
		s_next.pslverr = 1'b0;
		if (psel && !penable) begin
			s_next.pready = 1'b1;
			s_next.prdata = 32'h0000_0000;
			if (paddr == `DWPS_CTRL_OFS) begin
				s_next.prdata[`DWPS_CTRL_ILOCK_EN] = s_reg.ilock_en;
				s_next.prdata[`DWPS_CTRL_SIMUL] = s_reg.simul;
			end else if (paddr == `DWPS_MANUAL_OFS) begin
				s_next.prdata = 32'h0000_0000;
			end else if (paddr == `DWPS_UPDATE_OFS) begin
				s_next.prdata = 32'h0000_0000;
			end else if (paddr == `DWPS_MEM_ADDR_OFS) begin
				s_next.prdata = {15'h0000, s_reg.mem_addr};
			end else if (paddr == `DWPS_MEM_DATA_OFS) begin
				s_next.prdata = 32'h0000_0000;
			end else if (paddr == `DWPS_TIMER_OFS) begin
				s_next.prdata = {16'h0000, s_reg.timer_reload};
			end else if (paddr == `DWPS_STATUS_OFS) begin
				s_next.prdata = {7'h00, s_reg.rd_ptr, leadin,
					s_reg.ilock_en & s_reg.ilock_sync[1], s_reg.blank, s_reg.ch,
					(s_reg.state != dwps_pkg::DWPS_IDLE) & ~s_reg.pause_sync[1],
					s_reg.state != dwps_pkg::DWPS_IDLE};
			end else begin
				s_next.pslverr = 1'b1;
			end
		end

		// APB access edge: writes take effect here only
		// Play and stop are pulses; no register keeps them
		apb_wr = psel & penable & pwrite & s_reg.pready & ~s_reg.pslverr;
		if (apb_wr) begin
			if (paddr == `DWPS_CTRL_OFS) begin
				play_cmd = pwdata[`DWPS_CTRL_PLAY]; // [R4]
				stop_cmd = pwdata[`DWPS_CTRL_STOP];
				s_next.ilock_en = pwdata[`DWPS_CTRL_ILOCK_EN];
				s_next.simul = pwdata[`DWPS_CTRL_SIMUL];
			end else if (paddr == `DWPS_MANUAL_OFS) begin
				if (s_reg.simul) begin
					s_next.stage[pwdata[14:12]] = pwdata[11:0]; // [R18]
				end else begin
					s_next.dac[pwdata[14:12]] = pwdata[11:0]; // [R18]
				end
			end else if (paddr == `DWPS_UPDATE_OFS) begin
				s_next.dac = s_reg.stage; // [R18]
			end else if (paddr == `DWPS_MEM_ADDR_OFS) begin
				s_next.mem_addr = pwdata[`DWPS_MEM_AW-1:0];
			end else if (paddr == `DWPS_MEM_DATA_OFS) begin
				mem_we = 1'b1; // [R2]
				s_next.mem_addr = s_reg.mem_addr + 17'h00001;
			end else if (paddr == `DWPS_TIMER_OFS) begin
				s_next.timer_reload = pwdata[15:0];
			end
		end

		// Flag nibble decode of the word just read
		// Blank and reserved codes carry none of the four flag meanings
		// and still put their code out on the current channel
		nib = mem_rdata[`DWPS_HALT_BIT:`DWPS_LOOP_BIT]; // [R1]
		is_cmd = (nib == `DWPS_NIB_BLANK_OFF) || (nib == `DWPS_NIB_BLANK_ON) ||
			(nib == `DWPS_NIB_RSVD_A) || (nib == `DWPS_NIB_RSVD_B); // [R14]
		f_halt = nib[3] & ~is_cmd; // [R14]
		f_frame = nib[2] & ~is_cmd;
		f_last = nib[1] & ~is_cmd;
		f_loop = nib[0] & ~is_cmd;
		ch0 = (s_reg.ch == 3'h0);

		// Playback engine
		case (s_reg.state)
			dwps_pkg::DWPS_IDLE: begin
				// Waits for play or trigger, handled after the case
				s_next.state = dwps_pkg::DWPS_IDLE;
			end
			dwps_pkg::DWPS_RUN: begin
				// Read issued now; the word is in the read register next cycle
				if (strobe && s_reg.pause_sync[1]) begin // [R5]
					mem_re = 1'b1; // [R3]
					s_next.state = dwps_pkg::DWPS_LOAD;
				end
			end
			dwps_pkg::DWPS_LOAD: begin
				// Apply the fetched word, then move pointer and channel on
				s_next.dac[s_reg.ch] = mem_rdata[`DWPS_CODE_W-1:0]; // [R3]
				s_next.frame = f_frame | (s_reg.frame & ~ch0); // [R8] [R9]
				s_next.last = f_last | (s_reg.last & ~ch0); // [R7] [R9]
				if (nib == `DWPS_NIB_BLANK_ON) begin
					s_next.blank = 1'b1; // [R15]
				end else if (nib == `DWPS_NIB_BLANK_OFF) begin
					s_next.blank = 1'b0; // [R15]
				end
				if (f_loop && s_reg.loop_sync[1]) begin // [R13]
					s_next.rd_ptr = 17'h00000; // [R12] [R21]
					s_next.ch = 3'h0; // [R21]
				end else begin
					s_next.rd_ptr = s_reg.rd_ptr + 17'h00001; // [R11]
					if (f_last) begin
						s_next.ch = 3'h0; // [R6]
					end else begin
						s_next.ch = s_reg.ch + 3'h1; // [R6]
					end
				end
				if (f_halt) begin
					s_next.state = dwps_pkg::DWPS_IDLE; // [R10]
				end else begin
					s_next.state = dwps_pkg::DWPS_RUN;
				end
			end
			default: begin
				s_next.state = dwps_pkg::DWPS_IDLE;
			end
		endcase

		// Stop wins over start; start restarts from the first word
		// A stop in the load cycle still applies the word being loaded
		if (stop_cmd) begin
			s_next.state = dwps_pkg::DWPS_IDLE;
		end else if (play_cmd || trig_fall) begin // [R4]
			s_next.state = dwps_pkg::DWPS_RUN;
			s_next.rd_ptr = 17'h00000; // [R21]
			s_next.ch = 3'h0; // [R21]
		end

		// Output stage: zero during lead-in or active interlock
		// Zeroing acts on the outputs only; stored codes are kept
		// Playback and manual writes share the codes; last one wins
		zero_out = leadin | (s_reg.ilock_en & s_reg.ilock_sync[1]); // [R16] [R17]
		for (int i = 0; i < `DWPS_NUM_CH; i++) begin
			if (zero_out) begin
				s_next.out[i] = 12'h000; // [R16] [R17]
			end else begin
				s_next.out[i] = s_next.dac[i];
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Memory contents are not cleared; reset empties the state record and the memory read register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// Outputs, straight from the state register
	// ****************************************
	// Every output is a field of the state register
	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign dac_codes = s_reg.out;
	assign frame_out = s_reg.frame;
	assign last_channel_out = s_reg.last;
	assign blank_out = s_reg.blank;

endmodule

// [tb/dwps_top_monitor.sv]
/*
 * Port checker of the sequencer top: bus handshake, lead-in, pause.
 * Assumes it is bound to dwps_top and dwps_pkg is compiled first.
 */
`include "dwps_defs.svh"

module dwps_top_monitor #(
	parameter int unsigned LEADIN_CYCLES = `DWPS_LEADIN_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins
	input wire logic pause_n,
	input wire logic ilock,
	input wire dwps_pkg::dwps_codes_t dac_codes,
	input wire logic frame_out,
	input wire logic last_channel_out,
	input wire logic blank_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Cycles since reset release
	// ****************************************
	logic [31:0] lead_cnt;
	always_ff @(posedge clk_sys) begin
		if (rst)
			lead_cnt <= 32'h0;
		else if (lead_cnt < LEADIN_CYCLES)
			lead_cnt <= lead_cnt + 32'h1;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_ready_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (
		pready |-> psel && penable && $past(psel && !penable))
		else $error("pready without a setup");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response with data");
	a_leadin_zero: assert property (
		lead_cnt + 32'h1 < LEADIN_CYCLES |-> dac_codes == '0)
		else $error("codes during lead-in");
	a_reset_clear: assert property (
		$past(rst) |-> dac_codes == '0 && !frame_out && !last_channel_out && !blank_out)
		else $error("outputs not clear after reset");
	a_pause_codes: assert property (
		(!pause_n && !psel && $stable(ilock))[*8] |-> $stable(dac_codes))
		else $error("codes moved while paused");
	a_pause_flags: assert property (
		(!pause_n)[*8] |-> $stable({frame_out, last_channel_out}))
		else $error("flag pins moved while paused");

	c_err: cover property (pslverr);
	c_blank: cover property (blank_out);
	c_frame_fall: cover property ($fell(frame_out));
	c_last: cover property (last_channel_out);
endmodule

bind dwps_top dwps_top_monitor #(.LEADIN_CYCLES(LEADIN_CYCLES)) i_dwps_top_monitor (
	.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pause_n(pause_n), .ilock(ilock),
	.dac_codes(dac_codes), .frame_out(frame_out), .last_channel_out(last_channel_out),
	.blank_out(blank_out)
);

// [tb/dwps_pin_model.sv]
/*
 * Control pin side: four pulled-up lines that the outside may drive low.
 * Assumes the bench sets the drive requests off the clock edge.
 */
module dwps_pin_model (
	// Drive-low requests
	input wire logic trig_low,
	input wire logic pause_low,
	input wire logic ilock_low,
	input wire logic loop_low,
	// Pin levels
	output logic trig_n,
	output logic pause_n,
	output logic ilock,
	output logic loop_en
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released lines float up to the pull-up level
	assign trig_n = !trig_low;
	assign pause_n = !pause_low;
	assign ilock = !ilock_low;
	assign loop_en = !loop_low;
endmodule

// [tb/tb.sv]
/*
 * Self-checking bench of the sequencer with a playback model.
 * Assumes dwps_pkg, the design and the pin model are compiled first.
 */
`include "dwps_defs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned LEAD = 20;
	localparam logic [3:0] NIB [16] = '{4'h4, 4'h0, 4'hb, 4'h1, 4'h2, 4'h6, 4'h3, 4'h5,
		4'hd, 4'h7, 4'h9, 4'hf, 4'h9, 4'hb, 4'h0, 4'h0};
	logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic trig_low = 1'h0, pause_low = 1'h0, ilock_low = 1'h0, loop_low = 1'h1;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr, er, frame_out, last_channel_out, blank_out;
	logic trig_n, pause_n, ilock, loop_en, m_fr = 1'h0, m_la = 1'h0, m_bl = 1'h0;
	dwps_pkg::dwps_codes_t dac_codes;
	logic [15:0] lf = 16'h8fa2;
	logic [15:0] prog [16];
	logic [11:0] m_dac [8] = '{default: 12'h0};
	int fail_count = 0, checked = 0, cyc = 0;

	dwps_top #(.LEADIN_CYCLES(LEAD)) i_dwps_top (.clk_sys(clk_sys), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trig_n(trig_n), .pause_n(pause_n), .ilock(ilock),
		.loop_en(loop_en), .dac_codes(dac_codes), .frame_out(frame_out),
		.last_channel_out(last_channel_out), .blank_out(blank_out));
	dwps_pin_model i_dwps_pin_model (.trig_low(trig_low), .pause_low(pause_low),
		.ilock_low(ilock_low), .loop_low(loop_low), .trig_n(trig_n), .pause_n(pause_n),
		.ilock(ilock), .loop_en(loop_en));

	// ****************************************
	// Clock, hang guard and helpers
	// ****************************************
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			report_and_stop();
		end
	end

	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic report_and_stop();
		if (fail_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask

	// One APB transfer; read data and error kept in rd and er
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wait_idle();
		repeat (200) begin
			apb(1'h0, `DWPS_STATUS_OFS, 32'h0);
			if (rd[0] === 1'h0)
				break;
		end
		chk(32'(rd[0]), 32'h0);
	endtask

	task automatic cmp_all();
		#1;
		for (int i = 0; i < 8; i++)
			chk(32'(dac_codes[i]), 32'(m_dac[i]));
		chk(32'(frame_out), 32'(m_fr));
		chk(32'(last_channel_out), 32'(m_la));
		chk(32'(blank_out), 32'(m_bl));
	endtask

	// Playback model over prog; le is the loop enable level
	task automatic run_model(input logic le);
		int p, c;
		logic [3:0] n;
		p = 0;
		c = 0;
		for (int k = 0; k < 64; k++) begin
			n = prog[p][15:12];
			m_dac[c] = prog[p][11:0];
			p++;
			if (n[3] && n[0]) begin
				if (!n[2])
					m_bl = n[1];
				m_fr = (c == 0) ? 1'h0 : m_fr;
				m_la = (c == 0) ? 1'h0 : m_la;
				c = (c + 1) % 8;
			end else begin
				m_fr = (c == 0) ? n[2] : (m_fr | n[2]);
				m_la = (c == 0) ? n[1] : (m_la | n[1]);
				c = n[1] ? 0 : (c + 1) % 8;
				if (n[3])
					break;
				if (n[0] && le) begin
					p = 0;
					c = 0;
				end
			end
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (LEAD + 4) @(posedge clk_sys);
		apb(1'h0, 12'h100, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		apb(1'h0, `DWPS_TIMER_OFS, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, `DWPS_MEM_ADDR_OFS, 32'h10005);
		apb(1'h0, `DWPS_MEM_ADDR_OFS, 32'h0);
		chk(rd, 32'h10005);
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			m_dac[i] = lf[11:0];
			apb(1'h1, `DWPS_MANUAL_OFS, {17'h0, 3'(i), lf[11:0]});
			repeat (2) @(posedge clk_sys);
			#1 chk(32'(dac_codes[i]), 32'(m_dac[i]));
		end
		apb(1'h1, `DWPS_CTRL_OFS, 32'h8);
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			prog[i] = lf;
			apb(1'h1, `DWPS_MANUAL_OFS, {17'h0, 3'(i), lf[11:0]});
		end
		cmp_all();
		apb(1'h1, `DWPS_UPDATE_OFS, 32'h0);
		for (int i = 0; i < 8; i++)
			m_dac[i] = prog[i][11:0];
		repeat (2) @(posedge clk_sys);
		cmp_all();
		apb(1'h1, `DWPS_TIMER_OFS, 32'h3);
		for (int r = 0; r < 4; r++) begin
			apb(1'h1, `DWPS_MEM_ADDR_OFS, 32'h0);
			for (int k = 0; k < 16; k++) begin
				lf = nx(lf);
				prog[k] = {(k == 15) ? {1'h1, 2'(r), 1'h0} : NIB[k], lf[11:0]};
				apb(1'h1, `DWPS_MEM_DATA_OFS, {16'h0, prog[k]});
			end
			pause_low <= (r == 2);
			if (r[0]) begin
				apb(1'h1, `DWPS_CTRL_OFS, 32'h1);
			end else begin
				trig_low <= 1'h1;
				repeat (4) @(posedge clk_sys);
				trig_low <= 1'h0;
			end
			if (r == 2) begin
				repeat (40) @(posedge clk_sys);
				apb(1'h0, `DWPS_STATUS_OFS, 32'h0);
				chk(32'(rd[1:0]), 32'h3);
				cmp_all();
				pause_low <= 1'h0;
			end
			wait_idle();
			run_model(1'h0);
			cmp_all();
		end
		loop_low <= 1'h0;
		apb(1'h1, `DWPS_MEM_ADDR_OFS, 32'h0);
		for (int k = 0; k < 4; k++) begin
			lf = nx(lf);
			prog[k] = {(k == 3) ? 4'h8 : {3'h0, k == 2}, lf[11:0]};
			apb(1'h1, `DWPS_MEM_DATA_OFS, {16'h0, prog[k]});
		end
		apb(1'h1, `DWPS_CTRL_OFS, 32'h1);
		repeat (200) @(posedge clk_sys);
		apb(1'h0, `DWPS_STATUS_OFS, 32'h0);
		chk(32'(rd[0]), 32'h1);
		apb(1'h1, `DWPS_CTRL_OFS, 32'h2);
		wait_idle();
		run_model(1'h1);
		cmp_all();
		apb(1'h1, `DWPS_CTRL_OFS, 32'h4);
		repeat (5) @(posedge clk_sys);
		#1 chk(32'(|dac_codes), 32'h0);
		ilock_low <= 1'h1;
		repeat (5) @(posedge clk_sys);
		cmp_all();
		report_and_stop();
	end
endmodule
